/* File: hdl/mtf_pkg.sv */
// Purpose: Shared constants and types of the multi-channel timer
// Assumes: 32-bit classic Wishbone slave, byte addresses
// Notes: Counter held at 32 bits, masked to the variant width
package mtf_pkg;

  localparam int MTF_NCH = 4;
  localparam int MTF_CNT_W = 32;
  localparam int MTF_PSC_W = 16;
  localparam int MTF_DT_W = 8;
  localparam int MTF_FLD_W = 8;

  // Register byte offsets
  localparam logic [7:0] MTF_OFF_CTRL = 8'h00;
  localparam logic [7:0] MTF_OFF_PSC = 8'h04;
  localparam logic [7:0] MTF_OFF_ARR = 8'h08;
  localparam logic [7:0] MTF_OFF_CNT = 8'h0c;
  localparam logic [7:0] MTF_OFF_STAT = 8'h10;
  localparam logic [7:0] MTF_OFF_MASK = 8'h14;
  localparam logic [7:0] MTF_OFF_DEAD = 8'h18;
  localparam logic [7:0] MTF_OFF_CHCFG = 8'h1c;
  localparam logic [7:0] MTF_OFF_CCR0 = 8'h20;
  localparam logic [7:0] MTF_OFF_DMAEN = 8'h30;
  localparam logic [7:0] MTF_CCR_STEP = 8'h04;

  // Control fields
  localparam int MTF_CTRL_EN = 0;
  localparam int MTF_CTRL_DIR_LSB = 1;
  localparam int MTF_CTRL_OPM = 3;
  localparam int MTF_CTRL_ENC = 4;
  localparam int MTF_CTRL_HALL = 5;
  localparam int MTF_CTRL_TSTART = 6;
  localparam int MTF_CTRL_TRST = 7;
  localparam int MTF_CTRL_OUTEN = 8;
  localparam int MTF_CTRL_W = 9;

  // Status, mask and DMA enable layout
  localparam int MTF_ST_UPD = 0;
  localparam int MTF_ST_CH_LSB = 1;
  localparam int MTF_ST_W = 5;

  // Channel configuration field layout
  localparam int MTF_CF_MODE_LSB = 0;
  localparam int MTF_CF_EDGE = 2;
  localparam int MTF_CF_COMP = 3;

  // Reset value and width masks
  localparam logic [MTF_CNT_W-1:0] MTF_ARR_RST = 32'h0000ffff;
  localparam logic [MTF_CNT_W-1:0] MTF_W16_MASK = 32'h0000ffff;
  localparam logic [MTF_CNT_W-1:0] MTF_W32_MASK = 32'hffffffff;

  typedef enum logic [1:0] {
    MTF_ADV = 2'b00,
    MTF_WIDE = 2'b01,
    MTF_NARROW = 2'b10,
    MTF_BASIC = 2'b11
  } mtf_var_t;

  typedef enum logic [1:0] {
    MTF_CM_UP = 2'b00,
    MTF_CM_DN = 2'b01,
    MTF_CM_CTR = 2'b10,
    MTF_CM_RSV = 2'b11
  } mtf_cmode_t;

  typedef enum logic [1:0] {
    MTF_CH_OFF = 2'b00,
    MTF_CH_CAP = 2'b01,
    MTF_CH_CMP = 2'b10,
    MTF_CH_PWM = 2'b11
  } mtf_chmode_t;

  typedef enum logic {
    MTF_GO_UP = 1'b0,
    MTF_GO_DN = 1'b1
  } mtf_dir_t;

endpackage

/* File: hdl/mtf_chan_if.sv */
// Purpose: Link between the timer core and one channel
// Assumes: Single clock domain
// Notes: Core drives configuration, channel drives results
`timescale 1ns/1ps
interface mtf_chan_if;
  import mtf_pkg::*;
  logic [MTF_CNT_W-1:0] cnt;
  logic [MTF_CNT_W-1:0] ccr;
  mtf_chmode_t mode;
  logic cap_fall;
  logic comp_en;
  logic [MTF_DT_W-1:0] dead;
  logic tick;
  logic halt;
  logic cap_in;
  logic evt;
  logic cap_hit;
  logic [MTF_CNT_W-1:0] cap_val;
  logic out_p;
  logic out_n;
  modport core (output cnt, ccr, mode, cap_fall, comp_en, dead, tick,
    halt, cap_in, input evt, cap_hit, cap_val, out_p, out_n);
  modport chan (input cnt, ccr, mode, cap_fall, comp_en, dead, tick,
    halt, cap_in, output evt, cap_hit, cap_val, out_p, out_n);
endinterface

/* File: hdl/mtf_channel.sv */
// Purpose: One capture/compare/PWM channel with dead time
// Assumes: Capture pin synchronous to the clock
// Notes: Outputs are low while halted
`timescale 1ns/1ps
module mtf_channel
(
  input wire logic clock,
  input wire logic rst,
  mtf_chan_if.chan ch
);
  import mtf_pkg::*;

  logic cap_prev_q;
  logic toggle_q;
  logic ref_q;
  logic ref_d;
  logic [MTF_DT_W-1:0] dt_q;
  logic cap_edge;
  logic match;

  assign cap_edge = ch.cap_fall ? (cap_prev_q & ~ch.cap_in)
                                : (~cap_prev_q & ch.cap_in);
  assign match = ch.tick && (ch.cnt == ch.ccr);

  // Reference waveform per mode
  always_comb
  begin
    case (ch.mode)
      MTF_CH_PWM: ref_d = (ch.cnt < ch.ccr);
      MTF_CH_CMP: ref_d = toggle_q;
      default: ref_d = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cap_prev_q <= 1'b0;
      ch.cap_hit <= 1'b0;
      ch.cap_val <= '0;
    end
    else
    begin
      cap_prev_q <= ch.cap_in;
      ch.cap_hit <= (ch.mode == MTF_CH_CAP) && cap_edge;
      if ((ch.mode == MTF_CH_CAP) && cap_edge)
      begin
        ch.cap_val <= ch.cnt;
      end
    end
  end

  // Compare toggle and channel event
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      toggle_q <= 1'b0;
      ch.evt <= 1'b0;
    end
    else
    begin
      if ((ch.mode == MTF_CH_CMP) && match)
      begin
        toggle_q <= ~toggle_q;
      end
      ch.evt <= ((ch.mode == MTF_CH_CAP) && cap_edge) ||
                ((ch.mode != MTF_CH_CAP) && (ch.mode != MTF_CH_OFF) &&
                 match);
    end
  end

  // Dead time between complementary edges
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ref_q <= 1'b0;
      dt_q <= '0;
    end
    else
    begin
      ref_q <= ref_d;
      if (ref_d != ref_q)
      begin
        dt_q <= ch.dead;
      end
      else if (dt_q != '0)
      begin
        dt_q <= dt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ch.out_p <= 1'b0;
      ch.out_n <= 1'b0;
    end
    else if (ch.halt)
    begin
      ch.out_p <= 1'b0;
      ch.out_n <= 1'b0;
    end
    else if (ch.comp_en)
    begin
      ch.out_p <= ref_q && (dt_q == '0);
      ch.out_n <= !ref_q && (dt_q == '0);
    end
    else
    begin
      ch.out_p <= ref_q;
      ch.out_n <= 1'b0;
    end
  end

endmodule // mtf_channel

/* File: hdl/mtf_timer.sv */
// Purpose: Prescaled auto-reload timer with four channels
// Assumes: Classic Wishbone, pins synchronous to clock
// Notes: VARIANT picks advanced, wide, narrow or basic class
//
// Function
// - Advanced: 16-bit counter, four complementary channels
// - Channel modes: capture, compare, PWM; single pulse by the control OPM bit
// - Dead time between complementary output edges
// - PWM duty from zero to full
// - Debug halt freezes counter, disables PWM
// - Up, down, center counting; prescale 1..65536
// - Wide variant: 32-bit counter, four channels
// - Narrow variant: 16-bit counter, four channels
// - Auto-reload at limit, keep counting
// - Trigger link in and out between timers
// - Quadrature encoder and Hall sensor counting
// - Own DMA request output per timer
// - Usable as PWM source or plain counter
// - Advanced behaves as narrow timer too
// - Basic: 16-bit up counter only, stops in debug
`timescale 1ns/1ps
module mtf_timer
#(
  parameter mtf_pkg::mtf_var_t VARIANT = mtf_pkg::MTF_ADV
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [mtf_pkg::MTF_NCH-1:0] cap_in,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [3:0] hall,
  input wire logic trig_in,
  input wire logic debug_halt,
  output logic [mtf_pkg::MTF_NCH-1:0] pwm_p,
  output logic [mtf_pkg::MTF_NCH-1:0] pwm_n,
  output logic trig_out,
  output logic dma_req,
  output logic irq
);
  import mtf_pkg::*;

  localparam logic [MTF_CNT_W-1:0] WMASK =
    (VARIANT == MTF_WIDE) ? MTF_W32_MASK : MTF_W16_MASK;
  localparam logic IS_BASIC = (VARIANT == MTF_BASIC);
  localparam logic IS_ADV = (VARIANT == MTF_ADV);

  logic [MTF_CTRL_W-1:0] ctrl_q;
  logic [MTF_PSC_W-1:0] psc_q;
  logic [MTF_PSC_W-1:0] psc_cnt_q;
  logic [MTF_CNT_W-1:0] arr_q;
  logic [MTF_CNT_W-1:0] cnt_q;
  logic [MTF_CNT_W-1:0] cnt_d;
  mtf_dir_t dir_q;
  mtf_dir_t dir_d;
  logic [MTF_ST_W-1:0] stat_q;
  logic [MTF_ST_W-1:0] stat_d;
  logic [MTF_ST_W-1:0] mask_q;
  logic [MTF_ST_W-1:0] dmaen_q;
  logic [MTF_DT_W-1:0] dead_q;
  logic [MTF_NCH*MTF_FLD_W-1:0] chcfg_q;
  logic [MTF_CNT_W-1:0] ccr_q [MTF_NCH];
  logic [MTF_NCH-1:0] ch_evt;
  logic [MTF_ST_W-1:0] ev_set;
  logic ea_q;
  logic eb_q;
  logic [3:0] hall_q;
  logic [31:0] rd_data;
  logic acc;
  logic wr;
  logic run;
  logic psc_tick;
  logic enc_edge;
  logic enc_up;
  logic hall_edge;
  logic step;
  logic upd;
  logic trig_rst;
  logic [MTF_CNT_W-1:0] arr_eff;
  mtf_cmode_t cmode;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Wishbone strobes
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? rd_data : '0;
    end
  end

  // Counting mode; basic class only counts up
  assign cmode = IS_BASIC ? MTF_CM_UP
    : mtf_cmode_t'(ctrl_q[MTF_CTRL_DIR_LSB +: 2]);
  assign arr_eff = arr_q & WMASK;
  assign run = ctrl_q[MTF_CTRL_EN];

  // Prescaler divides by psc + 1
  assign psc_tick = run && !debug_halt && (psc_cnt_q == psc_q);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      psc_cnt_q <= '0;
    end
    else if (!run || psc_tick)
    begin
      psc_cnt_q <= '0;
    end
    else if (!debug_halt)
    begin
      psc_cnt_q <= psc_cnt_q + 1'b1;
    end
  end

  // Encoder and Hall edge sensing
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ea_q <= 1'b0;
      eb_q <= 1'b0;
      hall_q <= '0;
    end
    else
    begin
      ea_q <= enc_a;
      eb_q <= enc_b;
      hall_q <= hall;
    end
  end

  assign enc_edge = (enc_a ^ ea_q) | (enc_b ^ eb_q);
  assign enc_up = ea_q ^ enc_b;
  assign hall_edge = (hall != hall_q);

  always_comb
  begin
    if (!run || debug_halt)
    begin
      step = 1'b0;
    end
    else if (!IS_BASIC && ctrl_q[MTF_CTRL_ENC])
    begin
      step = enc_edge;
    end
    else if (!IS_BASIC && ctrl_q[MTF_CTRL_HALL])
    begin
      step = hall_edge;
    end
    else
    begin
      step = psc_tick;
    end
  end

  assign trig_rst = !IS_BASIC && trig_in && ctrl_q[MTF_CTRL_TRST];

  // Next count and update event
  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    upd = 1'b0;
    if (trig_rst)
    begin
      cnt_d = '0;
      dir_d = MTF_GO_UP;
    end
    else if (step && !IS_BASIC && ctrl_q[MTF_CTRL_ENC])
    begin
      if (enc_up)
      begin
        cnt_d = (cnt_q >= arr_eff) ? '0 : ((cnt_q + 1'b1) & WMASK);
      end
      else
      begin
        cnt_d = (cnt_q == '0) ? arr_eff : ((cnt_q - 1'b1) & WMASK);
      end
    end
    else if (step)
    begin
      case (cmode)
        MTF_CM_DN:
        begin
          if (cnt_q == '0)
          begin
            cnt_d = arr_eff;
            upd = 1'b1;
          end
          else
          begin
            cnt_d = (cnt_q - 1'b1) & WMASK;
          end
        end
        MTF_CM_CTR:
        begin
          if (dir_q == MTF_GO_UP && cnt_q >= arr_eff)
          begin
            dir_d = MTF_GO_DN;
            cnt_d = (arr_eff == '0) ? '0 : ((arr_eff - 1'b1) & WMASK);
            upd = 1'b1;
          end
          else if (dir_q == MTF_GO_DN && cnt_q == '0)
          begin
            dir_d = MTF_GO_UP;
            cnt_d = (arr_eff == '0) ? '0 : 32'h1;
            upd = 1'b1;
          end
          else if (dir_q == MTF_GO_UP)
          begin
            cnt_d = (cnt_q + 1'b1) & WMASK;
          end
          else
          begin
            cnt_d = (cnt_q - 1'b1) & WMASK;
          end
        end
        default:
        begin
          if (cnt_q >= arr_eff)
          begin
            cnt_d = '0;
            upd = 1'b1;
          end
          else
          begin
            cnt_d = (cnt_q + 1'b1) & WMASK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      dir_q <= MTF_GO_UP;
    end
    else if (wr && wb_adr_i == MTF_OFF_CNT)
    begin
      cnt_q <= merge(cnt_q, wb_dat_i, wb_sel_i) & WMASK;
    end
    else
    begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  // Control; single pulse stops on update, trigger may start
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= '0;
    end
    else
    begin
      if (wr && wb_adr_i == MTF_OFF_CTRL)
      begin
        ctrl_q <= MTF_CTRL_W'(merge(32'(ctrl_q), wb_dat_i, wb_sel_i));
      end
      else if (upd && ctrl_q[MTF_CTRL_OPM])
      begin
        ctrl_q[MTF_CTRL_EN] <= 1'b0;
      end
      else if (!IS_BASIC && trig_in && ctrl_q[MTF_CTRL_TSTART])
      begin
        ctrl_q[MTF_CTRL_EN] <= 1'b1;
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      psc_q <= '0;
      arr_q <= MTF_ARR_RST;
      mask_q <= '0;
      dmaen_q <= '0;
      dead_q <= '0;
      chcfg_q <= '0;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        MTF_OFF_PSC:
          psc_q <= MTF_PSC_W'(merge(32'(psc_q), wb_dat_i, wb_sel_i));
        MTF_OFF_ARR:
          arr_q <= merge(arr_q, wb_dat_i, wb_sel_i) & WMASK;
        MTF_OFF_MASK:
          mask_q <= MTF_ST_W'(merge(32'(mask_q), wb_dat_i, wb_sel_i));
        MTF_OFF_DMAEN:
          dmaen_q <= MTF_ST_W'(merge(32'(dmaen_q), wb_dat_i, wb_sel_i));
        MTF_OFF_DEAD:
          dead_q <= MTF_DT_W'(merge(32'(dead_q), wb_dat_i, wb_sel_i));
        MTF_OFF_CHCFG:
          chcfg_q <= merge(chcfg_q, wb_dat_i, wb_sel_i);
        default:
          dead_q <= dead_q;
      endcase
    end
  end

  // Channels; all forced to off mode in the basic class
  generate
    for (genvar g = 0; g < MTF_NCH; g++)
    begin : g_ch
      mtf_chan_if chif ();
      localparam logic [7:0] OFF = MTF_OFF_CCR0 + 8'(g) * MTF_CCR_STEP;

      assign chif.cnt = cnt_q;
      assign chif.ccr = ccr_q[g];
      assign chif.mode = IS_BASIC ? MTF_CH_OFF
        : mtf_chmode_t'(chcfg_q[g*MTF_FLD_W+MTF_CF_MODE_LSB +: 2]);
      assign chif.cap_fall = chcfg_q[g*MTF_FLD_W+MTF_CF_EDGE];
      assign chif.comp_en = IS_ADV && chcfg_q[g*MTF_FLD_W+MTF_CF_COMP];
      assign chif.dead = dead_q;
      assign chif.tick = step;
      assign chif.halt = debug_halt || !ctrl_q[MTF_CTRL_OUTEN];
      assign chif.cap_in = cap_in[g];
      assign ch_evt[g] = chif.evt;
      assign pwm_p[g] = chif.out_p;
      assign pwm_n[g] = chif.out_n;

      mtf_channel u_ch
      (
        .clock(clock),
        .rst(rst),
        .ch(chif.chan)
      );

      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
        begin
          ccr_q[g] <= '0;
        end
        else if (chif.cap_hit)
        begin
          ccr_q[g] <= chif.cap_val;
        end
        else if (wr && wb_adr_i == OFF)
        begin
          ccr_q[g] <= merge(ccr_q[g], wb_dat_i, wb_sel_i) & WMASK;
        end
      end
    end
  endgenerate

  // Sticky status, write one to clear, set wins
  assign ev_set = {ch_evt, upd};
  always_comb
  begin
    stat_d = stat_q;
    if (wr && wb_adr_i == MTF_OFF_STAT)
    begin
      stat_d = stat_q & ~(wb_sel_i[0] ? wb_dat_i[MTF_ST_W-1:0] : '0);
    end
    stat_d = stat_d | ev_set;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stat_q <= '0;
      irq <= 1'b0;
      dma_req <= 1'b0;
      trig_out <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      irq <= |(stat_d & mask_q);
      dma_req <= |(ev_set & dmaen_q);
      trig_out <= upd;
    end
  end

  // Read multiplexer; unmapped reads return zero
  always_comb
  begin
    rd_data = '0;
    case (wb_adr_i)
      MTF_OFF_CTRL: rd_data = 32'(ctrl_q);
      MTF_OFF_PSC: rd_data = 32'(psc_q);
      MTF_OFF_ARR: rd_data = arr_q;
      MTF_OFF_CNT: rd_data = cnt_q;
      MTF_OFF_STAT: rd_data = 32'(stat_q);
      MTF_OFF_MASK: rd_data = 32'(mask_q);
      MTF_OFF_DEAD: rd_data = 32'(dead_q);
      MTF_OFF_CHCFG: rd_data = chcfg_q;
      MTF_OFF_DMAEN: rd_data = 32'(dmaen_q);
      default:
      begin
        for (int i = 0; i < MTF_NCH; i++)
        begin
          if (wb_adr_i == MTF_OFF_CCR0 + 8'(i) * MTF_CCR_STEP)
          begin
            rd_data = ccr_q[i];
          end
        end
      end
    endcase
  end

endmodule // mtf_timer

/* File: tb/mtf_timer_sva.sv */
// Purpose: Port-level checks of the timer
// Assumes: Bound to every mtf_timer instance
// Notes: Sees the top module ports only
`timescale 1ns/1ps
module mtf_timer_sva
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [3:0] cap_in,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [3:0] hall,
  input wire logic trig_in,
  input wire logic debug_halt,
  input wire logic [3:0] pwm_p,
  input wire logic [3:0] pwm_n,
  input wire logic trig_out,
  input wire logic dma_req,
  input wire logic irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  halt_pwm_a: assert property (
    debug_halt [*3] |-> (pwm_p == 4'h0 && pwm_n == 4'h0))
    else $error("outputs active while halted");
  pair_apart_a: assert property ((pwm_p & pwm_n) == 4'h0)
    else $error("both outputs of a pair high");
  trig_pulse_a: assert property (trig_out |=> !trig_out)
    else $error("trigger out not a pulse");
  irq_clear_a: assert property ($fell(irq) |->
    ($past(wb_ack_o && wb_we_i) || (wb_ack_o && wb_we_i)))
    else $error("irq fell without a write");
endmodule // mtf_timer_sva
bind mtf_timer mtf_timer_sva u_mtf_timer_sva (.clock(clock), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cap_in(cap_in), .enc_a(enc_a),
  .enc_b(enc_b), .hall(hall), .trig_in(trig_in), .debug_halt(debug_halt),
  .pwm_p(pwm_p), .pwm_n(pwm_n), .trig_out(trig_out), .dma_req(dma_req),
  .irq(irq));

/* File: tb/mtf_pin_model.sv */
// Purpose: Encoder and capture pins on the far side
// Assumes: Requests from the bench, one clock
// Notes: Encoder steps forward in Gray order
`timescale 1ns/1ps
module mtf_pin_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic enc_step,
  input wire logic [3:0] cap_req,
  output logic enc_a,
  output logic enc_b,
  output logic [3:0] cap_in
);
  logic [1:0] ph_q;
  always_ff @(posedge clock or posedge rst)
    if (rst)
      ph_q <= 2'h0;
    else if (enc_step)
      ph_q <= ph_q + 2'h1;
  // Phases 00,01,11,10 on a,b
  assign enc_a = ph_q[1];
  assign enc_b = ph_q[1] ^ ph_q[0];
  always_ff @(posedge clock or posedge rst)
    if (rst)
      cap_in <= 4'h0;
    else
      cap_in <= cap_req;
endmodule // mtf_pin_model

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench of the timer
// Assumes: Advanced variant, bus master by tasks
// Notes: Hall and link trigger inputs driven by the bench
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_top;
  import mtf_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, enc_step = 1'b0, halt = 1'b0;
  logic trig = 1'b0;
  logic [3:0] hall_v = 4'h0;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'h0, cap_req = 4'h0, cap_in, pwm_p, pwm_n;
  logic [31:0] dat = 32'h0, rdat, q, a0, v;
  logic [31:0] exp_q[$];
  logic wb_ack_o, enc_a, enc_b, trig_out, dma_req, irq;
  logic [31:0] wb_dat_o;
  int n_fail = 0, samples_checked = 0, cycles = 0, n_trig = 0, n_dma = 0;
  int n_gap = 0;
  int seed = 32'hfa4eb694;
  always #2 clock = ~clock;
  mtf_timer #(.VARIANT(MTF_ADV)) u_mtf_timer (.clock(clock), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cap_in(cap_in), .enc_a(enc_a), .enc_b(enc_b),
    .hall(hall_v), .trig_in(trig), .debug_halt(halt), .pwm_p(pwm_p),
    .pwm_n(pwm_n), .trig_out(trig_out), .dma_req(dma_req), .irq(irq));
  mtf_pin_model u_mtf_pin_model (.clock(clock), .rst(rst),
    .enc_step(enc_step), .cap_req(cap_req), .enc_a(enc_a), .enc_b(enc_b),
    .cap_in(cap_in));
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    n_trig += (trig_out === 1'b1);
    n_dma += (dma_req === 1'b1);
    if (cycles > 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clock);
    while (wb_ack_o !== 1'b1)
      @(posedge clock);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic poll(input logic [31:0] m);
    rdat = 32'h0;
    for (int k = 0; k < 60 && (rdat & m) == 32'h0; k++)
      rd(MTF_OFF_STAT);
  endtask
  task automatic pwm_hold(input logic p);
    repeat (8) @(posedge clock);
    repeat (12)
    begin
      @(posedge clock);
      `CHK(pwm_p[0], p)
      `CHK(pwm_n[0], ~p)
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(MTF_OFF_ARR);
    `CHK(rdat, MTF_ARR_RST)
    rd(MTF_OFF_CTRL);
    `CHK(rdat, 32'h0)
    wr(8'h40, 32'h5a5a5a5a);
    rd(8'h40);
    `CHK(rdat, 32'h0)
    wr(MTF_OFF_PSC, 32'h00001234);
    wb(1'b1, MTF_OFF_PSC, 32'h0000beab, 4'h1);
    rd(MTF_OFF_PSC);
    `CHK(rdat, 32'h000012ab)
    for (int c = 0; c < MTF_NCH; c++)
    begin
      v = $random(seed) & 32'h0000ffff;
      exp_q.push_back(v);
      wr(MTF_OFF_CCR0 + 8'(4 * c), v);
    end
    for (int c = 0; c < MTF_NCH; c++)
    begin
      rd(MTF_OFF_CCR0 + 8'(4 * c));
      `CHK(rdat, exp_q.pop_front())
    end
    v = $random(seed) & 32'h0000ffff;
    wr(MTF_OFF_CNT, v);
    wr(MTF_OFF_CHCFG, 32'h00000100);
    cap_req <= 4'h2;
    repeat (4) @(posedge clock);
    cap_req <= 4'h0;
    rd(MTF_OFF_CCR0 + 8'h04);
    `CHK(rdat, v)
    rd(MTF_OFF_STAT);
    `CHK(rdat[2], 1'b1)
    wr(MTF_OFF_CHCFG, 32'h0);
    wr(MTF_OFF_ARR, 32'h2);
    wr(MTF_OFF_PSC, 32'h0);
    wr(MTF_OFF_DMAEN, 32'h1);
    for (int m = 0; m < 3; m++)
    begin
      wr(MTF_OFF_MASK, (m == 2) ? 32'h0 : 32'h1);
      wr(MTF_OFF_STAT, 32'h1f);
      wr(MTF_OFF_CTRL, 32'h1 | (m << 1));
      poll(32'h1);
      `CHK(rdat[0], 1'b1)
      `CHK(irq, (m != 2))
      wr(MTF_OFF_CTRL, 32'h0);
      wr(MTF_OFF_STAT, 32'h1f);
      repeat (3) @(posedge clock);
      `CHK(irq, 1'b0)
    end
    `CHK(n_trig > 0, 1'b1)
    `CHK(n_dma > 0, 1'b1)
    wr(MTF_OFF_CTRL, 32'h9);
    poll(32'h1);
    repeat (3) @(posedge clock);
    rd(MTF_OFF_CTRL);
    `CHK(rdat[0], 1'b0)
    wr(MTF_OFF_CHCFG, 32'h0000000b);
    wr(MTF_OFF_DEAD, 32'h2);
    wr(MTF_OFF_CCR0, 32'h0);
    wr(MTF_OFF_CTRL, 32'h101);
    pwm_hold(1'b0);
    wr(MTF_OFF_CCR0, 32'h3);
    n_gap = 0;
    repeat (8)
    begin
      @(posedge clock);
      n_gap += (pwm_p[0] === 1'b0 && pwm_n[0] === 1'b0);
    end
    `CHK(n_gap, 2)
    pwm_hold(1'b1);
    halt <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK(pwm_p, 4'h0)
    rd(MTF_OFF_CNT);
    a0 = rdat;
    repeat (5) @(posedge clock);
    rd(MTF_OFF_CNT);
    `CHK(rdat, a0)
    halt <= 1'b0;
    wr(MTF_OFF_CTRL, 32'h0);
    wr(MTF_OFF_ARR, 32'h0000ffff);
    wr(MTF_OFF_CNT, 32'h0);
    wr(MTF_OFF_CTRL, 32'h11);
    repeat (8)
    begin
      @(posedge clock);
      enc_step <= 1'b1;
      @(posedge clock);
      enc_step <= 1'b0;
      repeat (2) @(posedge clock);
    end
    rd(MTF_OFF_CNT);
    `CHK(rdat, 32'h8)
    wr(MTF_OFF_CTRL, 32'h0);
    wr(MTF_OFF_CNT, 32'h0);
    wr(MTF_OFF_CCR0 + 8'h08, 32'h1);
    wr(MTF_OFF_CHCFG, 32'h00020000);
    wr(MTF_OFF_STAT, 32'h1f);
    wr(MTF_OFF_CTRL, 32'h121);
    repeat (3)
    begin
      hall_v <= hall_v + 4'h1;
      repeat (3) @(posedge clock);
    end
    rd(MTF_OFF_CNT);
    `CHK(rdat, 32'h3)
    rd(MTF_OFF_STAT);
    `CHK(rdat[3], 1'b1)
    `CHK(pwm_p[2], 1'b1)
    wr(MTF_OFF_CTRL, 32'h80);
    trig <= 1'b1;
    @(posedge clock);
    trig <= 1'b0;
    rd(MTF_OFF_CNT);
    `CHK(rdat, 32'h0)
    wr(MTF_OFF_CTRL, 32'h40);
    trig <= 1'b1;
    @(posedge clock);
    trig <= 1'b0;
    rd(MTF_OFF_CTRL);
    `CHK(rdat[0], 1'b1)
    give_verdict();
  end
endmodule // tb_top
